// ===== rtl/lpc_pkg.sv
// Package with register map, field positions and reset values of the LED PWM controller.
package lpc_pkg;

  // AXI4-Lite widths.
  localparam int AXI_ADDR_W = 16;
  localparam int AXI_DATA_W = 32;

  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] CTRL_IDX = 16'h3400;
  localparam logic [15:0] DIV_IDX = 16'h3402;
  localparam logic [15:0] RED_IDX = 16'h3404;
  localparam logic [15:0] CTRL_ADDR = {CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] DIV_ADDR = {DIV_IDX[13:0], 2'b00};
  localparam logic [15:0] RED_ADDR = {RED_IDX[13:0], 2'b00};

  // Control register field positions.
  localparam int BLUE_EN_BIT = 11;
  localparam int GREEN_EN_BIT = 10;
  localparam int RED_EN_BIT = 9;
  localparam int WHITE_EN_BIT = 8;
  localparam int AUDIO_SEL_BIT = 5;
  localparam int AUDIO_EN_BIT = 4;
  localparam int POLARITY_BIT = 2;
  localparam int RGB_OE_BIT = 1;
  localparam int WHITE_OE_BIT = 0;

  // Writable bits of each register; all other bits read as zero.
  localparam logic [15:0] CTRL_WMASK = 16'h0f37;
  localparam logic [15:0] DIV_WMASK = 16'h000f;
  localparam logic [15:0] RED_WMASK = 16'h7f7f;

  // Red on/off point fields.
  localparam int RED_OFF_LSB = 8;
  localparam int RED_ON_LSB = 0;
  localparam int STEP_W = 7;

  // Reset values.
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] RED_RESET = 16'h0000;

  // Divider: highest valid code; codes above it stop the PWM clock.
  localparam logic [3:0] DIV_MAX_CODE = 4'h8;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/lpc_clk_div.sv
// Programmable divider that makes the step tick for the colour channels.
`timescale 1ns/10ps
module lpc_clk_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run_ce,
  input wire logic [3:0] code,
  output logic tick
);
  import lpc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] limit;
  logic stopped;
  logic [4:0] twice;

  // Code 0 divides by one, code n divides by 2n, codes above eight stop.
  always_comb begin
    twice = {code, 1'b0} - 5'h01;
    limit = (code == 4'h0) ? 4'h0 : twice[3:0];
    stopped = (code > DIV_MAX_CODE);
  end

  // The counter restarts on any value at or past the limit, so a smaller code takes effect at once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
    end else if (run_ce) begin
      if (stopped) begin
        cnt_reg <= 4'h0;
        tick <= 1'b0;
      end else if (cnt_reg >= limit) begin
        cnt_reg <= 4'h0;
        tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
        tick <= 1'b0;
      end
    end
  end

endmodule

// ===== rtl/lpc_led_pwm.sv
// Four-channel LED pulse-width modulator with an AXI4-Lite register port.
// Notes on behaviour
// - Red enable low forces red PWM value to zero before polarity.
// - All colour enables low clears the 128-step counter to zero.
// - White enable low forces white PWM value to zero before polarity.
// - Audio gating enable lets the audio input gate the colour outputs.
// - Audio select low enables colours on high input, high on low.
// - Polarity low inverts all four pins; polarity high passes them straight.
// - Colour output enable low holds red, green and blue pins high.
// - White output enable low holds the white pin high.
// - Both output enables and all channel enables low stop the PWM clock.
// - Divide field sets colour step clock divider; white is unaffected.
// - Code zero divides by one, code n by 2n, up to 16.
// - Divide codes nine to fifteen stop the PWM clock.
// - Red off field is the turn-off step, coded as off time minus one.
// - Turn-on value zero starts the on phase at the first step.
// - Turn-off value 7fh keeps the LED on to the cycle end.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module lpc_led_pwm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [lpc_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [lpc_pkg::AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [lpc_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [lpc_pkg::AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic audio_gate_in,
  output logic red_led_out,
  output logic green_led_out,
  output logic blue_led_out,
  output logic white_led_out
);
  import lpc_pkg::*;

  // Register state.
  logic [15:0] ctrl_reg;
  logic [15:0] div_reg;
  logic [15:0] red_reg;

  // Write channel holding state.
  logic aw_held_reg;
  logic w_held_reg;
  logic [15:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic do_write;
  logic [15:0] byte_mask;

  // PWM state.
  logic audio_meta_reg;
  logic audio_sync_reg;
  logic [STEP_W-1:0] step_cnt_reg;
  logic div_tick;
  logic pwm_run;
  logic run_ce;
  logic rgb_any_en;
  logic audio_ok;
  logic red_window;
  logic red_val;
  logic green_val;
  logic blue_val;
  logic white_val;
  logic [STEP_W-1:0] red_on;
  logic [STEP_W-1:0] red_off;
  logic pol;

  // Write address channel: take it once, hold it until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      awready <= 1'b1;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
        awready <= 1'b0;
      end else if (bvalid && bready) begin
        aw_held_reg <= 1'b0;
        awready <= 1'b1;
      end
    end
  end

  // Write data channel: independent of the address so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'b00;
      wready <= 1'b1;
    end else if (clk_en) begin
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata[15:0];
        w_strb_reg <= wstrb[1:0];
        wready <= 1'b0;
      end else if (bvalid && bready) begin
        w_held_reg <= 1'b0;
        wready <= 1'b1;
      end
    end
  end

  // A write commits in the cycle both halves are held and no response is pending.
  always_comb begin
    do_write = aw_held_reg && w_held_reg && !bvalid;
    byte_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  end

  // Write response; unmapped addresses answer with a slave error and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid <= 1'b1;
        if (aw_addr_reg[15:2] == CTRL_ADDR[15:2]) begin
          bresp <= RESP_OKAY;
        end else if (aw_addr_reg[15:2] == DIV_ADDR[15:2]) begin
          bresp <= RESP_OKAY;
        end else if (aw_addr_reg[15:2] == RED_ADDR[15:2]) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register file. Reserved bits are masked off so they always read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      div_reg <= DIV_RESET;
      red_reg <= RED_RESET;
    end else if (clk_en && do_write) begin
      if (aw_addr_reg[15:2] == CTRL_ADDR[15:2]) begin
        ctrl_reg <= ((ctrl_reg & ~byte_mask) | (w_data_reg & byte_mask)) & CTRL_WMASK;
      end else if (aw_addr_reg[15:2] == DIV_ADDR[15:2]) begin
        div_reg <= ((div_reg & ~byte_mask) | (w_data_reg & byte_mask)) & DIV_WMASK;
      end else if (aw_addr_reg[15:2] == RED_ADDR[15:2]) begin
        red_reg <= ((red_reg & ~byte_mask) | (w_data_reg & byte_mask)) & RED_WMASK;
      end
    end
  end

  // Read channel: one read at a time, answered in the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        if (araddr[15:2] == CTRL_ADDR[15:2]) begin
          rdata <= {16'h0000, ctrl_reg};
          rresp <= RESP_OKAY;
        end else if (araddr[15:2] == DIV_ADDR[15:2]) begin
          rdata <= {16'h0000, div_reg};
          rresp <= RESP_OKAY;
        end else if (araddr[15:2] == RED_ADDR[15:2]) begin
          rdata <= {16'h0000, red_reg};
          rresp <= RESP_OKAY;
        end else begin
          rdata <= 32'h00000000;
          rresp <= RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // The audio pin is asynchronous, so it passes two flip-flops before use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      audio_meta_reg <= 1'b0;
      audio_sync_reg <= 1'b0;
    end else if (clk_en) begin
      audio_meta_reg <= audio_gate_in;
      audio_sync_reg <= audio_meta_reg;
    end
  end

  // Run control. The PWM logic only advances while some enable is set.
  always_comb begin
    rgb_any_en = ctrl_reg[RED_EN_BIT] | ctrl_reg[GREEN_EN_BIT] | ctrl_reg[BLUE_EN_BIT];
    pwm_run = rgb_any_en | ctrl_reg[WHITE_EN_BIT] | ctrl_reg[RGB_OE_BIT] | ctrl_reg[WHITE_OE_BIT];
    run_ce = clk_en && pwm_run;
    red_on = red_reg[RED_ON_LSB +: STEP_W];
    red_off = red_reg[RED_OFF_LSB +: STEP_W];
    pol = ctrl_reg[POLARITY_BIT];
  end

  // Step clock divider for the colour channels only.
  lpc_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run_ce(run_ce),
    .code(div_reg[3:0]),
    .tick(div_tick)
  );

  // Step counter wraps naturally at 128; held at zero while no colour channel is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt_reg <= 7'h00;
    end else if (clk_en) begin
      if (!rgb_any_en) begin
        step_cnt_reg <= 7'h00;
      end else if (run_ce && div_tick) begin
        step_cnt_reg <= step_cnt_reg + 7'h01;
      end
    end
  end

  // Internal PWM values before polarity and output enables.
  always_comb begin
    audio_ok = !ctrl_reg[AUDIO_EN_BIT] || (audio_sync_reg ^ ctrl_reg[AUDIO_SEL_BIT]);
    red_window = (step_cnt_reg >= red_on) && (step_cnt_reg <= red_off);
    red_val = ctrl_reg[RED_EN_BIT] && red_window && audio_ok;
    // Green and blue have no points in this block, so they run fully on when enabled.
    green_val = ctrl_reg[GREEN_EN_BIT] && audio_ok;
    blue_val = ctrl_reg[BLUE_EN_BIT] && audio_ok;
    white_val = ctrl_reg[WHITE_EN_BIT];
  end

  // Pin stage: disabled groups are held high, otherwise polarity decides inversion.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      red_led_out <= 1'b1;
      green_led_out <= 1'b1;
      blue_led_out <= 1'b1;
      white_led_out <= 1'b1;
    end else if (clk_en) begin
      red_led_out <= !ctrl_reg[RGB_OE_BIT] || (red_val == pol);
      green_led_out <= !ctrl_reg[RGB_OE_BIT] || (green_val == pol);
      blue_led_out <= !ctrl_reg[RGB_OE_BIT] || (blue_val == pol);
      white_led_out <= !ctrl_reg[WHITE_OE_BIT] || (white_val == pol);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A disabled red channel shows the polarity-inverted zero on its pin.
  red_disable_a: assert property (clk_en && !ctrl_reg[RED_EN_BIT] && ctrl_reg[RGB_OE_BIT]
      |=> red_led_out == !$past(pol))
    else $error("red pin not at disabled level");

  // With no colour enable the counter sits at zero.
  cnt_clear_a: assert property (clk_en && !rgb_any_en |=> step_cnt_reg == 7'h00)
    else $error("step counter not cleared");

  // A disabled white channel shows the polarity-inverted zero on its pin.
  white_disable_a: assert property (clk_en && !white_val && ctrl_reg[WHITE_OE_BIT]
      |=> white_led_out == !$past(pol))
    else $error("white pin not at disabled level");

  // An enabled white channel follows the polarity bit on its pin.
  white_run_a: assert property (clk_en && ctrl_reg[WHITE_EN_BIT] && ctrl_reg[WHITE_OE_BIT]
      |=> white_led_out == $past(pol))
    else $error("enabled white pin wrong");

  // A stopped colour divider leaves the white channel running.
  white_free_a: assert property (clk_en && ctrl_reg[WHITE_EN_BIT] && ctrl_reg[WHITE_OE_BIT]
      && div_reg[3:0] > DIV_MAX_CODE |=> white_led_out == $past(pol))
    else $error("white pin stopped with divider");

  // Audio at its inactive level drives all colour pins to the off level.
  audio_gate_a: assert property (clk_en && ctrl_reg[AUDIO_EN_BIT] && ctrl_reg[RGB_OE_BIT]
      && (audio_sync_reg == ctrl_reg[AUDIO_SEL_BIT]) |=>
      red_led_out == !$past(pol) && green_led_out == !$past(pol) && blue_led_out == !$past(pol))
    else $error("audio gate did not turn colours off");

  // Audio at its active level lets an enabled green channel through.
  audio_pass_a: assert property (clk_en && ctrl_reg[AUDIO_EN_BIT] && ctrl_reg[RGB_OE_BIT]
      && ctrl_reg[GREEN_EN_BIT] && (audio_sync_reg != ctrl_reg[AUDIO_SEL_BIT]) |=> green_led_out == $past(pol))
    else $error("audio gate blocked an active level");

  // Audio gating off: an enabled green channel is on whatever the audio pin does.
  audio_ignore_a: assert property (clk_en && !ctrl_reg[AUDIO_EN_BIT] && ctrl_reg[RGB_OE_BIT]
      && ctrl_reg[GREEN_EN_BIT] |=> green_led_out == $past(pol))
    else $error("audio input leaked through");

  // Colour output enable low holds all three colour pins high.
  rgb_hold_a: assert property (clk_en && !ctrl_reg[RGB_OE_BIT]
      |=> red_led_out && green_led_out && blue_led_out)
    else $error("colour pins not held high");

  // White output enable low holds the white pin high.
  white_hold_a: assert property (clk_en && !ctrl_reg[WHITE_OE_BIT] |=> white_led_out)
    else $error("white pin not held high");

  // With everything idle the step counter never moves once its clear has landed one cycle in.
  clock_gate_a: assert property (!pwm_run [*3] |-> $stable(step_cnt_reg))
    else $error("step counter moved while gated");

  // Gating the PWM clock freezes the divider output as well as the counter.
  clock_stop_a: assert property (!pwm_run |=> $stable(div_tick))
    else $error("divider moved while gated");

  // Stopped divider codes freeze the step counter.
  div_stop_a: assert property ((div_reg[3:0] > DIV_MAX_CODE && rgb_any_en) [*3] |-> $stable(step_cnt_reg))
    else $error("step counter moved with stopped divider");

  // Code two gives exactly one tick every four cycles.
  div_ratio_a: assert property ((div_tick && run_ce && div_reg[3:0] == 4'h2)
      ##1 (run_ce && div_reg[3:0] == 4'h2 && !div_tick) [*3] |=> div_tick)
    else $error("divide by four tick spacing wrong");

  // Each tick moves the enabled counter one step, wrapping from the last step to zero.
  step_wrap_a: assert property (run_ce && div_tick && rgb_any_en
      |=> step_cnt_reg == $past(step_cnt_reg) + 7'h01)
    else $error("step counter did not advance");

  // Red is on from its on step through its off step.
  red_window_a: assert property (clk_en && red_val == 1'b0 && ctrl_reg[RED_EN_BIT]
      && !ctrl_reg[AUDIO_EN_BIT] |-> (step_cnt_reg < red_on) || (step_cnt_reg > red_off))
    else $error("red off inside its window");

  // An on value of zero lights red at step zero.
  red_start_a: assert property (clk_en && ctrl_reg[RED_EN_BIT] && ctrl_reg[RGB_OE_BIT] && pol
      && !ctrl_reg[AUDIO_EN_BIT] && red_on == 7'h00 && step_cnt_reg == 7'h00 |=> red_led_out)
    else $error("red not on at first step");

  // An off value of 7fh keeps red on through the last step.
  red_full_a: assert property (clk_en && ctrl_reg[RED_EN_BIT] && ctrl_reg[RGB_OE_BIT] && pol
      && !ctrl_reg[AUDIO_EN_BIT] && red_off == 7'h7f && step_cnt_reg == 7'h7f
      && red_on <= red_off |=> red_led_out)
    else $error("red not on at last step");

endmodule

// ===== tb/lpc_far_side.sv
// Far-side model: counts LED driver pin levels and drives the digital audio input.
`timescale 1ns/10ps
module lpc_far_side (
  input wire logic aclk,
  input wire logic red_led_out,
  input wire logic white_led_out,
  output logic audio_gate_in
);
  // The audio line starts low, as an idle source would leave it.
  initial begin
    audio_gate_in <= 1'b0;
  end

  // Changes land just after an edge; the design still treats the line as asynchronous and synchronises it.
  task automatic set_audio(input logic level);
    @(posedge aclk);
    audio_gate_in <= level;
  endtask

  // Counts the cycles in which each driven pin is high over a window of n cycles.
  task automatic measure(input int n, output int red_hi, output int white_hi);
    red_hi = 0;
    white_hi = 0;
    repeat (n) begin
      @(posedge aclk);
      red_hi += (red_led_out === 1'b1);
      white_hi += (white_led_out === 1'b1);
    end
  endtask
endmodule

// ===== tb/lpc_led_pwm_bench.sv
// Self-checking bench for the LED PWM controller and its register port.
`timescale 1ns/10ps
module lpc_led_pwm_bench;
  import lpc_pkg::*;
  logic aclk, aresetn, clk_en;
  logic [15:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic audio_gate_in, red_led_out, green_led_out, blue_led_out, white_led_out;
  int err_count = 0;
  int tests_run = 0;

  lpc_led_pwm u_lpc_led_pwm (.aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .audio_gate_in, .red_led_out, .green_led_out, .blue_led_out, .white_led_out);

  lpc_far_side u_lpc_far_side (.aclk, .red_led_out, .white_led_out, .audio_gate_in);

  // The 40 MHz clock stands in for the slow LED source clock; every check counts steps, so the rate scales.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Prints the verdict once and ends the run.
  task automatic test_done;
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares register words, responses and pulse counts.
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compares single pin levels.
  task automatic check_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Write: address and data offered together, each released when taken, bready held until bvalid.
  task automatic axi_write(input logic [15:0] a, input logic [15:0] d, input logic [1:0] exp_r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    check_bit("write answered", 1'b1, bvalid);
    check_val("bresp", {30'h0, exp_r}, {30'h0, bresp});
  endtask

  // Read: address held until taken, rready held until rvalid.
  task automatic axi_read(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    check_bit("read answered", 1'b1, rvalid);
    check_val("rdata", exp, rdata);
    check_val("rresp", {30'h0, exp_r}, {30'h0, rresp});
  endtask

  // Reset values, writable masks and an unmapped address.
  task automatic test_regs;
    logic [15:0] addrs [3] = '{CTRL_ADDR, DIV_ADDR, RED_ADDR};
    logic [15:0] masks [3] = '{CTRL_WMASK, DIV_WMASK, RED_WMASK};
    logic [15:0] rsts [3] = '{CTRL_RESET, DIV_RESET, RED_RESET};
    check_bit("red pin at reset", 1'b1, red_led_out);
    check_bit("white pin at reset", 1'b1, white_led_out);
    for (int i = 0; i < 3; i++) begin
      axi_read(addrs[i], {16'h0000, rsts[i]}, RESP_OKAY);
      axi_write(addrs[i], 16'hffff, RESP_OKAY);
      axi_read(addrs[i], {16'h0000, masks[i]}, RESP_OKAY);
      axi_write(addrs[i], 16'h0000, RESP_OKAY);
    end
    axi_write(16'hd004, 16'hffff, RESP_SLVERR);
    axi_read(16'hd004, 32'h0000_0000, RESP_SLVERR);
  endtask

  // Enables, output enables and polarity on static levels; each entry is control, white, red.
  task automatic test_pins;
    logic [17:0] tbl [7] = '{{16'h0001, 2'b11}, {16'h0005, 2'b01}, {16'h0105, 2'b11}, {16'h0101, 2'b01},
      {16'h0100, 2'b11}, {16'h0006, 2'b10}, {16'h0002, 2'b11}};
    for (int i = 0; i < 7; i++) begin
      axi_write(CTRL_ADDR, tbl[i][17:2], RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_bit("white pin", tbl[i][1], white_led_out);
      check_bit("red pin", tbl[i][0], red_led_out);
    end
  endtask

  // Red on window over one undivided cycle of 128 steps; each entry is off then on.
  task automatic test_points;
    logic [13:0] pts [4] = '{{7'h7f, 7'h00}, {7'h19, 7'h0a}, {7'h01, 7'h00}, {7'h7e, 7'h05}};
    int r, w;
    axi_write(DIV_ADDR, 16'h0000, RESP_OKAY);
    axi_write(CTRL_ADDR, 16'h0206, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axi_write(RED_ADDR, {1'b0, pts[i][13:7], 1'b0, pts[i][6:0]}, RESP_OKAY);
      repeat (4) @(posedge aclk);
      u_lpc_far_side.measure(128, r, w);
      check_val("red on steps", 32'(pts[i][13:7] - pts[i][6:0] + 1), 32'(r));
    end
  endtask

  // Every divide code: colour steps stretch by the ratio and white stays steady on codes 0 to 8, reserved codes freeze red.
  task automatic test_divider;
    int r, w, ratio;
    axi_write(RED_ADDR, 16'h3f00, RESP_OKAY);
    axi_write(CTRL_ADDR, 16'h0307, RESP_OKAY);
    for (int c = 0; c < 16; c++) begin
      ratio = (c == 0) ? 1 : 2 * c;
      axi_write(DIV_ADDR, 16'(c), RESP_OKAY);
      repeat (40) @(posedge aclk);
      if (c <= 8) begin
        u_lpc_far_side.measure(128 * ratio, r, w);
        check_val("red high cycles", 32'(64 * ratio), 32'(r));
        check_val("white high cycles", 32'(128 * ratio), 32'(w));
      end else begin
        u_lpc_far_side.measure(256, r, w);
        check_bit("red frozen", 1'b1, (r == 0 || r == 256));
      end
    end
  endtask

  // Audio gating over enable, level select and input level, checked on all three colours.
  task automatic test_audio;
    logic exp;
    axi_write(DIV_ADDR, 16'h0000, RESP_OKAY);
    axi_write(RED_ADDR, 16'h7f00, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      exp = !i[2] || (i[0] ^ i[1]);
      axi_write(CTRL_ADDR, 16'h0e06 | (16'(i[2]) << 4) | (16'(i[1]) << 5), RESP_OKAY);
      u_lpc_far_side.set_audio(i[0]);
      repeat (5) @(posedge aclk);
      check_bit("red gated", exp, red_led_out);
      check_bit("green gated", exp, green_led_out);
      check_bit("blue gated", exp, blue_led_out);
    end
  endtask

  // Turning all colours off mid-cycle must bring the step counter back to zero.
  task automatic test_restart;
    int n;
    n = 0;
    axi_write(DIV_ADDR, 16'h0008, RESP_OKAY);
    axi_write(RED_ADDR, 16'h3f00, RESP_OKAY);
    axi_write(CTRL_ADDR, 16'h0206, RESP_OKAY);
    // Let the pins show the new control word, so a stale gated level cannot end the wait early.
    repeat (3) @(posedge aclk);
    while (red_led_out !== 1'b0 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    check_bit("red reached off", 1'b1, n < 4000);
    axi_write(CTRL_ADDR, 16'h0006, RESP_OKAY);
    axi_write(CTRL_ADDR, 16'h0206, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check_bit("red after restart", 1'b1, red_led_out);
  endtask

  // Main sequence: inputs settled at time zero, reset for ten cycles, then the scenarios.
  initial begin
    clk_en = 1'b1;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs;
    test_pins;
    test_points;
    test_divider;
    test_audio;
    test_restart;
    test_done;
  end

  // The scenarios need roughly 15000 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    test_done;
  end
endmodule
